// file: dv/break_match_monitor.sv
// Checker of bus, break and error timing of the breakpoint match block
`timescale 1ns/100ps
`include "break_match_map.svh"
module break_match_monitor (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        imb_cycle,
	input wire logic [3:0]  imb_function_code,
	input wire logic        ext_cycle,
	input wire logic        break_signal,
	input wire logic        external_break_out,
	input wire logic        bus_error
);
	logic valid_reg;
	logic valid_next;
	logic bas_reg;
	logic bas_next;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Shadow of the valid and ack support bits, taken on the edge at which a control write lands
	always_comb begin
		valid_next = valid_reg;
		bas_next   = bas_reg;
		if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `ADDR_BREAK_CONTROL) begin
			if (wb_sel_i[0])
				valid_next = wb_dat_i[`CTL_VALID];
			if (wb_sel_i[2])
				bas_next = wb_dat_i[`CTL_BAS];
		end
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			valid_reg <= 1'b0;
			bas_reg   <= 1'b0;
		end else begin
			valid_reg <= valid_next;
			bas_reg   <= bas_next;
		end
	end
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_unmapped;
		wb_ack_o && !wb_we_i && wb_adr_i != `ADDR_BREAK_ADDRESS && wb_adr_i != `ADDR_BREAK_CONTROL
			|-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_brk_cause;
		break_signal |-> $past(imb_cycle);
	endproperty
	a_brk_cause: assert property (p_brk_cause) else $error("break without bus cycle");
	property p_brk_end;
		!imb_cycle |=> !break_signal;
	endproperty
	a_brk_end: assert property (p_brk_end) else $error("break outlives cycle");
	property p_ext_cause;
		external_break_out |-> $past(ext_cycle, 2) || $past(ext_cycle, 3);
	endproperty
	a_ext_cause: assert property (p_ext_cause) else $error("external break without cycle");
	property p_ext_pulse;
		external_break_out |=> !external_break_out [*3];
	endproperty
	a_ext_pulse: assert property (p_ext_pulse) else $error("external break repeated");
	property p_berr;
		bus_error |-> $past(imb_cycle) && $past(imb_function_code) == `CPU_SPACE_FC;
	endproperty
	a_berr: assert property (p_berr) else $error("bus error without ack cycle");
	property p_no_valid;
		!valid_reg |=> !break_signal && !external_break_out;
	endproperty
	a_no_valid: assert property (p_no_valid) else $error("break while valid bit clear");
	property p_berr_off;
		!bas_reg |=> !bus_error;
	endproperty
	a_berr_off: assert property (p_berr_off) else $error("bus error while ack support clear");
	c_brk: cover property (break_signal);
	c_ext: cover property (external_break_out);
	c_berr: cover property (bus_error);
endmodule
bind break_match break_match_monitor i_break_match_monitor (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .imb_cycle, .imb_function_code, .ext_cycle,
	.break_signal, .external_break_out, .bus_error);

// file: dv/break_match_tb.sv
// Self-checking bench of the breakpoint match block
`timescale 1ns/100ps
`include "break_match_map.svh"
module break_match_tb;
	logic        core_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0]  wb_adr_i = '0, wb_sel_i = '0, imb_function_code, f;
	logic [31:0] wb_dat_i = '0, wb_dat_o, imb_addr, ext_addr, ba, c, a;
	logic        wb_ack_o, imb_cycle, imb_write, ext_cycle, ext_write, ext_burst, w, imb_seen = 1'b0;
	logic        break_signal, external_break_out, bus_error, ext_done = 1'b0;
	logic [1:0]  imb_size, ext_size, ext_transfer_type, s;
	logic [2:0]  ext_transfer_modifier;
	int          n_errors = 0, checks = 0, pulses = 0, q_ext[$];
	logic [31:0] q_rd[$];
	logic [1:0]  q_imb[$];
	always #50 core_clk = ~core_clk;
	break_match i_break_match (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .imb_cycle, .imb_addr, .imb_size, .imb_write, .imb_function_code,
		.ext_cycle, .ext_addr, .ext_size, .ext_write, .ext_burst, .ext_transfer_type, .ext_transfer_modifier,
		.break_signal, .external_break_out, .bus_error);
	bus_cycle_model i_bus_cycle_model (.core_clk, .imb_cycle, .imb_addr, .imb_size, .imb_write,
		.imb_function_code, .ext_cycle, .ext_addr, .ext_size, .ext_write, .ext_burst, .ext_transfer_type,
		.ext_transfer_modifier);
	task automatic stop_test;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp_word(input string nm, input logic [31:0] e, g);
		checks++;
		if (e !== g) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_count(input string nm, input int e, g);
		checks++;
		if (e != g) begin
			n_errors++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, sel, input logic [31:0] d);
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, d};
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask
	task automatic rd(input logic [3:0] adr, input logic [31:0] e);
		q_rd.push_back(e);
		wb(1'b0, adr, 4'hF, 32'h0000_0000);
	endtask
	task automatic ext_case(input logic [31:0] x, y, input logic [1:0] tt, input logic [2:0] tm,
		input logic b, input int e);
		q_ext.push_back(e);
		i_bus_cycle_model.ext(x, y, tt, tm, b);
		ext_done <= 1'b1;
		@(posedge core_clk);
		ext_done <= 1'b0;
	endtask
	function automatic logic ref_hit(input logic [31:0] b, k, x, input logic [1:0] sz, input logic wr,
		input logic [3:0] fc);
		int  n;
		logic am;
		n = (sz == 2'h0) ? 4 : (sz == 2'h1) ? 1 : (sz == 2'h2) ? 2 : 3;
		if (k[11:10] != `MASK_NONE) begin
			am = ((((x ^ b) >> (9 + 2 * k[11:10])) == 0) != k[12]);
		end else if (k[15]) begin
			am = (x[31:2] == b[31:2]) && (b[1:0] >= x[1:0]) && (b[1:0] - x[1:0] < n);
		end else begin
			am = (x == b) && (sz == k[14:13]);
		end
		return k[0] && am && !(fc[3] ? k[9] : k[1 + fc[2:0]]) && (k[17:16] == `DIR_BOTH ||
			(k[17:16] == `DIR_READ && !wr) || (k[17:16] == `DIR_WRITE && wr));
	endfunction
	always @(posedge core_clk) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) begin
			cmp_word("read data", q_rd.pop_front(), wb_dat_o);
		end
		if (imb_seen) begin
			cmp_word("imb flags", {30'h0, q_imb.pop_front()}, {30'h0, bus_error, break_signal});
		end
		imb_seen <= imb_cycle;
		if (nrst && external_break_out !== 1'b0) pulses++;
		if (ext_done) begin
			cmp_count("ext pulses", q_ext.pop_front(), pulses);
			pulses = 0;
		end
	end
	initial begin
		#2_000_000;
		n_errors++;
		stop_test();
	end
	initial begin
		void'($urandom(66817));
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		rd(`ADDR_BREAK_ADDRESS, `ADDR_RESET);
		rd(`ADDR_BREAK_CONTROL, `CTL_RESET);
		wb(1'b1, `ADDR_BREAK_CONTROL, 4'h1, 32'hFFFF_FFFF);
		rd(`ADDR_BREAK_CONTROL, 32'h0000_00FF);
		wb(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF);
		rd(4'h8, 32'h0000_0000);
		repeat (150) begin
			ba = $urandom;
			c = $urandom & ~32'h0004_0000;
			if ($urandom_range(1)) ba[19:16] = 4'h0;
			if ($urandom_range(1)) c[9:1] = 9'h000;
			wb(1'b1, `ADDR_BREAK_ADDRESS, 4'hF, ba);
			wb(1'b1, `ADDR_BREAK_CONTROL, 4'hF, c);
			rd(`ADDR_BREAK_CONTROL, c & `CTL_WRITABLE);
			repeat (6) begin
				a = ba ^ ($urandom_range(1) ? ($urandom & 32'h0000_0003) : (32'h0000_0001 << $urandom_range(16)));
				{s, w, f} = 7'($urandom);
				q_imb.push_back({c[19] && f == `CPU_SPACE_FC && a[19:16] == 4'h0, ref_hit(ba, c, a, s, w, f)});
				i_bus_cycle_model.internal_module_bus(a, s, w, f);
			end
			i_bus_cycle_model.imb_idle();
		end
		ba = 32'h0012_3450;
		wb(1'b1, `ADDR_BREAK_ADDRESS, 4'hF, ba);
		wb(1'b1, `ADDR_BREAK_CONTROL, 4'hF, 32'h0006_2141);
		ext_case(ba, ba, `TT_NORMAL, 3'h1, 1'b0, 1);
		ext_case(ba | 32'h0000_0003, ba, `TT_NORMAL, 3'h1, 1'b0, 0);
		ext_case(ba, ba, `TT_ACK, 3'h1, 1'b0, 0);
		ext_case(ba, ba, `TT_NORMAL, 3'h5, 1'b0, 0);
		ext_case(ba, ba, `TT_NORMAL, 3'h6, 1'b0, 1);
		ext_case(ba, ba, 2'h1, 3'h5, 1'b0, 1);
		ext_case(ba ^ 32'h0000_0100, ba, `TT_NORMAL, 3'h1, 1'b1, 0);
		wb(1'b1, `ADDR_BREAK_CONTROL, 4'hF, `CTL_RESET);
		repeat (4) @(posedge core_clk);
		stop_test();
	end
endmodule

// file: dv/bus_cycle_model.sv
// Far-side master issuing internal and external memory cycles
`timescale 1ns/100ps
module bus_cycle_model (
	input wire logic    core_clk,
	output logic        imb_cycle,
	output logic [31:0] imb_addr,
	output logic [1:0]  imb_size,
	output logic        imb_write,
	output logic [3:0]  imb_function_code,
	output logic        ext_cycle,
	output logic [31:0] ext_addr,
	output logic [1:0]  ext_size,
	output logic        ext_write,
	output logic        ext_burst,
	output logic [1:0]  ext_transfer_type,
	output logic [2:0]  ext_transfer_modifier
);
	initial begin
		{imb_cycle, imb_addr, imb_size, imb_write, imb_function_code} = '0;
		{ext_cycle, ext_addr, ext_size, ext_write, ext_burst, ext_transfer_type, ext_transfer_modifier} = '0;
	end
	task automatic internal_module_bus(input logic [31:0] a, input logic [1:0] s, input logic w, input logic [3:0] f);
		@(posedge core_clk);
		{imb_cycle, imb_addr, imb_size, imb_write, imb_function_code} <= {1'b1, a, s, w, f};
	endtask
	// Released address and write lines show the inverse so stale values never match
	task automatic imb_idle;
		@(posedge core_clk);
		{imb_cycle, imb_addr, imb_write} <= {1'b0, ~imb_addr, ~imb_write};
	endtask
	task automatic ext(input logic [31:0] a, a2, input logic [1:0] tt, input logic [2:0] tm, input logic b);
		@(posedge core_clk);
		{ext_cycle, ext_addr, ext_size, ext_write, ext_burst, ext_transfer_type, ext_transfer_modifier} <=
			{1'b1, a, 2'h0, 1'b0, b, tt, tm};
		repeat (4) @(posedge core_clk);
		if (b) ext_addr <= a2;
		repeat (4) @(posedge core_clk);
		{ext_cycle, ext_addr, ext_burst} <= {1'b0, ~ext_addr, 1'b0};
		repeat (6) @(posedge core_clk);
	endtask
endmodule

// file: logic/break_match.sv
// Breakpoint address match with Wishbone register access
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "break_match_map.svh"
module break_match
	import break_match_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        imb_cycle,
	input  wire logic [31:0] imb_addr,
	input  wire logic [1:0]  imb_size,
	input  wire logic        imb_write,
	input  wire logic [3:0]  imb_function_code,
	input  wire logic        ext_cycle,
	input  wire logic [31:0] ext_addr,
	input  wire logic [1:0]  ext_size,
	input  wire logic        ext_write,
	input  wire logic        ext_burst,
	input  wire logic [1:0]  ext_transfer_type,
	input  wire logic [2:0]  ext_transfer_modifier,
	output logic             break_signal,
	output logic             external_break_out,
	output logic             bus_error
);
	import break_match_pkg::*;

	logic [31:0]  break_address_reg;
	logic [31:0]  break_address_next;
	logic [31:0]  break_control_reg;
	logic [31:0]  break_control_next;
	wb_state_t    wb_state_reg;
	wb_state_t    wb_state_next;
	logic [31:0]  rdata_reg;
	logic [31:0]  rdata_next;
	logic         ack_reg;
	logic         ack_next;
	burst_state_t burst_reg;
	burst_state_t burst_next;
	logic         int_break_reg;
	logic         int_break_next;
	logic         ext_break_reg;
	logic         ext_break_next;
	logic         berr_reg;
	logic         berr_next;
	logic         ext_cyc_prev_reg;
	logic         ext_cyc_prev_next;

	// External pins cross into core_clk before use
	logic [41:0]  ext_sync;
	logic         ext_cycle_s;
	logic [31:0]  ext_addr_s;
	logic [1:0]   ext_size_s;
	logic         ext_write_s;
	logic         ext_burst_s;
	logic [1:0]   ext_tt_s;
	logic [2:0]   ext_tm_s;

	cycle_sync #(
		.WIDTH(42)
	) u_ext_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({ext_cycle, ext_addr, ext_size, ext_write, ext_burst, ext_transfer_type,
			ext_transfer_modifier}),
		.sync_out (ext_sync)
	);

	assign {ext_cycle_s, ext_addr_s, ext_size_s, ext_write_s, ext_burst_s, ext_tt_s, ext_tm_s} = ext_sync;

	// Source selection; a word-wide sample is only safe while the pins hold steady
	logic        use_ext;
	logic        src_cycle;
	logic [31:0] src_addr;
	logic [1:0]  src_size;
	logic        src_write;
	logic        hit;
	logic        first_beat;
	logic        ack_cycle;

	assign use_ext = break_control_reg[`CTL_MATCH_BUS_SELECT];

	always_comb begin
		// Bus select picks the watched bus
		if (use_ext) begin
			src_cycle = ext_cycle_s;
			src_addr  = ext_addr_s;
			src_size  = ext_size_s;
			src_write = ext_write_s;
		end else begin
			src_cycle = imb_cycle;
			src_addr  = imb_addr;
			src_size  = imb_size;
			src_write = imb_write;
		end
	end

	match_compare u_cmp (
		.break_address_bits (break_address_reg),
		.ctl                (break_control_reg),
		.ext_cycle          (use_ext),
		.cyc_addr           (src_addr),
		.cyc_size           (src_size),
		.cyc_write          (src_write),
		.function_code      (imb_function_code),
		.transfer_type      (ext_tt_s),
		.transfer_modifier  (ext_tm_s),
		.hit                (hit)
	);

	// Register bus: ack one cycle after the request, then a closing cycle
	always_comb begin
		wb_state_next      = wb_state_reg;
		break_address_next = break_address_reg;
		break_control_next = break_control_reg;
		rdata_next         = rdata_reg;
		ack_next           = 1'b0;
		case (wb_state_reg)
			WB_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					ack_next      = 1'b1;
					wb_state_next = WB_ACK;
					case (wb_adr_i)
						`ADDR_BREAK_ADDRESS: rdata_next = break_address_reg;
						`ADDR_BREAK_CONTROL: rdata_next = break_control_reg;
						default:             rdata_next = 32'h0000_0000;
					endcase
				end
			end
			// Writes land on the edge at which the master sees ack, while it still holds the request
			WB_ACK: begin
				wb_state_next = WB_CLOSE;
				if (wb_cyc_i && wb_stb_i && wb_we_i) begin
					case (wb_adr_i)
						`ADDR_BREAK_ADDRESS: begin
							for (int b = 0; b < 4; b++) begin
								if (wb_sel_i[b])
									break_address_next[b*8 +: 8] = wb_dat_i[b*8 +: 8];
							end
						end
						`ADDR_BREAK_CONTROL: begin
							for (int b = 0; b < 4; b++) begin
								if (wb_sel_i[b])
									break_control_next[b*8 +: 8] = wb_dat_i[b*8 +: 8];
							end
							break_control_next = break_control_next & `CTL_WRITABLE;
						end
						default: wb_state_next = WB_CLOSE;
					endcase
				end
			end
			WB_CLOSE: begin
				if (!(wb_cyc_i && wb_stb_i))
					wb_state_next = WB_IDLE;
			end
			default: wb_state_next = WB_IDLE;
		endcase
	end

	// Match decision and burst tracking
	always_comb begin
		burst_next        = burst_reg;
		ext_cyc_prev_next = ext_cycle_s;
		first_beat        = 1'b1;
		// Only the first beat of an external burst is compared
		case (burst_reg)
			BURST_NONE: begin
				if (ext_cycle_s && ext_burst_s)
					burst_next = BURST_BEATS;
			end
			BURST_BEATS: begin
				first_beat = 1'b0;
				if (!ext_burst_s || !ext_cycle_s)
					burst_next = BURST_NONE;
			end
			default: burst_next = BURST_NONE;
		endcase
		// One external decision per cycle, on its first sampled clock; an internal hit breaks on every clock
		int_break_next = 1'b0;
		ext_break_next = 1'b0;
		if (src_cycle && hit && break_control_reg[`CTL_VALID]) begin
			if (!use_ext) begin
				int_break_next = 1'b1;
			end else if (!ext_cyc_prev_reg && first_beat) begin
				ext_break_next = 1'b1;
			end
		end
		if (!break_control_reg[`CTL_VALID]) begin
			int_break_next = 1'b0;
			ext_break_next = 1'b0;
		end
		// Bus error on core breakpoint acknowledge
		ack_cycle = imb_cycle && imb_function_code == `CPU_SPACE_FC && imb_addr[19:16] == 4'h0;
		berr_next = break_control_reg[`CTL_BAS] && ack_cycle;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wb_state_reg      <= WB_IDLE;
			break_address_reg <= `ADDR_RESET;
			break_control_reg <= `CTL_RESET;
			rdata_reg         <= 32'h0000_0000;
			ack_reg           <= 1'b0;
		end else begin
			wb_state_reg      <= wb_state_next;
			break_address_reg <= break_address_next;
			break_control_reg <= break_control_next;
			rdata_reg         <= rdata_next;
			ack_reg           <= ack_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			burst_reg         <= BURST_NONE;
			int_break_reg     <= 1'b0;
			ext_break_reg     <= 1'b0;
			berr_reg          <= 1'b0;
			ext_cyc_prev_reg  <= 1'b0;
		end else begin
			burst_reg         <= burst_next;
			int_break_reg     <= int_break_next;
			ext_break_reg     <= ext_break_next;
			berr_reg          <= berr_next;
			ext_cyc_prev_reg  <= ext_cyc_prev_next;
		end
	end

	assign wb_dat_o           = rdata_reg;
	assign wb_ack_o           = ack_reg;
	// Internal line for bus cycles, external line for outside cycles
	assign break_signal       = int_break_reg;
	assign external_break_out = ext_break_reg;
	assign bus_error          = berr_reg;
endmodule

// file: logic/break_match_map.svh
// Offsets, field positions, reset values and encodings of the breakpoint match block
// Notes on behaviour
// - A match drives the external break line or the internal break line by source.
// - External bus cycles always match as if size masking were set.
// - In an external burst only the first address is compared.
// - Direction 00 reads, 01 writes, 10 both; 11 reserved, never matches.
// - Size masking cleared: access size must equal the programmed size.
// - Size masking set: any access overlapping the programmed byte matches.
// - Exact mode needs address and size equal; 00 long, 01 byte, 10 word, 11 three.
// - Size compare applies only while address block mask is 00.
// - Overlap follows byte lanes of programmed A1-A0 against access A1-A0 and size.
// - Break only when the programmed byte is really part of the access.
// - Negative match with a block mask breaks on addresses outside the block.
// - Negative match is ignored when the address block mask is 00.
// - Negative match inverts only the address compare.
// - Mask 00 compares 32 bits; 01 drops 10-0; 10 drops 12-0; 11 drops 14-0.
// - Nine space bits mask function code spaces; bit 8 covers 1xxx.
// - Transfer type cycles: bit 7 masks type 11, bits 6-0 type 00 by modifier.
// - No break while the valid bit is cleared.
// - Bus select cleared uses internal bus; set uses external bus, A1-A0 ignored; with mask 00 the code still lane-checks access A1-A0 there.
// - Ack support set gives a bus error on core breakpoint acknowledge cycles.
// - A separate 32-bit register holds the compare address.
`ifndef BREAK_MATCH_MAP_SVH
`define BREAK_MATCH_MAP_SVH

`define ADDR_BREAK_ADDRESS 4'h0
`define ADDR_BREAK_CONTROL 4'h4

`define CTL_VALID     0
`define CTL_SPACE_LO  1
`define CTL_SPACE_HI  9
`define CTL_MASK_LO   10
`define CTL_MASK_HI   11
`define CTL_NEG       12
`define CTL_SIZE_LO   13
`define CTL_SIZE_HI   14
`define CTL_SIZE_MASK_ENABLE      15
`define CTL_DIR_LO    16
`define CTL_DIR_HI    17
`define CTL_MATCH_BUS_SELECT      18
`define CTL_BAS       19
`define CTL_WRITABLE  32'h000F_FFFF
`define CTL_RESET     32'h0000_0000
`define ADDR_RESET    32'h0000_0000

`define DIR_READ  2'h0
`define DIR_WRITE 2'h1
`define DIR_BOTH  2'h2

`define SIZE_LONG  2'h0
`define SIZE_BYTE  2'h1
`define SIZE_WORD  2'h2
`define SIZE_THREE 2'h3

`define MASK_NONE 2'h0
`define MASK_2K   2'h1
`define MASK_8K   2'h2
`define MASK_32K  2'h3

`define CPU_SPACE_FC 4'h7
`define TT_NORMAL    2'h0
`define TT_ACK       2'h3

`endif

// file: logic/break_match_pkg.sv
// Types shared by the breakpoint match block
package break_match_pkg;
	typedef enum logic [2:0] {
		WB_IDLE  = 3'b001,
		WB_ACK   = 3'b010,
		WB_CLOSE = 3'b100
	} wb_state_t;

	typedef enum logic [1:0] {
		BURST_NONE  = 2'b01,
		BURST_BEATS = 2'b10
	} burst_state_t;
endpackage

// file: logic/cycle_sync.sv
// Two-flop synchroniser for external bus pins
`timescale 1ns/100ps
module cycle_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule

// file: logic/match_compare.sv
// Combinational address, size, direction and space compare of one bus cycle
`timescale 1ns/100ps
`include "break_match_map.svh"
module match_compare (
	input  wire logic [31:0] break_address_bits,
	input  wire logic [31:0] ctl,
	input  wire logic        ext_cycle,
	input  wire logic [31:0] cyc_addr,
	input  wire logic [1:0]  cyc_size,
	input  wire logic        cyc_write,
	input  wire logic [3:0]  function_code,
	input  wire logic [1:0]  transfer_type,
	input  wire logic [2:0]  transfer_modifier,
	output logic             hit
);
	// Bytes touched by an access, one bit per lane 0..3 of the long word
	function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] sz);
		logic [2:0] n;
		logic [3:0] m;
		n = (sz == `SIZE_LONG) ? 3'h4 : {1'b0, sz};
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if (3'(i) >= {1'b0, a} && 3'(i) < ({1'b0, a} + n))
				m[i] = 1'b1;
		end
		return m;
	endfunction

	logic [1:0]  amask;
	logic [31:0] keep;
	logic        addr_eq;
	logic        addr_ok;
	logic        size_ok;
	logic        dir_ok;
	logic        space_ok;
	logic [8:0]  space;
	logic [3:0]  acc_lanes;

	always_comb begin
		amask = ctl[`CTL_MASK_HI:`CTL_MASK_LO];
		space = ctl[`CTL_SPACE_HI:`CTL_SPACE_LO];
		case (amask)
			`MASK_2K:  keep = 32'hFFFF_F800;
			`MASK_8K:  keep = 32'hFFFF_E000;
			`MASK_32K: keep = 32'hFFFF_8000;
			default:   keep = 32'hFFFF_FFFF;
		endcase
		// Overlap mode and the external bus leave A1-A0 to the lane check
		if (ext_cycle || ctl[`CTL_SIZE_MASK_ENABLE])
			keep[1:0] = 2'b00;
		acc_lanes = lanes(cyc_addr[1:0], cyc_size);
		addr_eq = ((cyc_addr ^ break_address_bits) & keep) == 32'h0000_0000;
		// Inversion of the address term only
		if (amask != `MASK_NONE && ctl[`CTL_NEG])
			addr_ok = !addr_eq;
		else
			addr_ok = addr_eq;
		if (amask != `MASK_NONE)
			size_ok = 1'b1;
		else if (!ctl[`CTL_SIZE_MASK_ENABLE] && !ext_cycle)
			size_ok = (cyc_size == ctl[`CTL_SIZE_HI:`CTL_SIZE_LO]) &&
				(cyc_addr[1:0] == break_address_bits[1:0]);
		else
			size_ok = acc_lanes[break_address_bits[1:0]];
		// Direction select, reserved code never matches
		case (ctl[`CTL_DIR_HI:`CTL_DIR_LO])
			`DIR_READ:  dir_ok = !cyc_write;
			`DIR_WRITE: dir_ok = cyc_write;
			`DIR_BOTH:  dir_ok = 1'b1;
			default:    dir_ok = 1'b0;
		endcase
		// Space masking by function code or transfer type
		if (ext_cycle) begin
			if (transfer_type == `TT_ACK)
				space_ok = !space[7];
			else if (transfer_type == `TT_NORMAL)
				space_ok = !(transfer_modifier != 3'h7 && space[transfer_modifier]);
			else
				space_ok = 1'b1;
		end else if (function_code[3]) begin
			space_ok = !space[8];
		end else begin
			space_ok = !space[function_code[2:0]];
		end
		hit = addr_ok && size_ok && dir_ok && space_ok;
	end
endmodule
